// File: cub_pkg.sv
`default_nettype none
package cub_pkg;
	// ----------------------------------------------------------------
	// bus map
	// ----------------------------------------------------------------
	localparam int          CUB_AW        = 5;
	localparam int          CUB_DW        = 32;
	localparam logic [4:0]  CUB_OFF_CTRL  = 5'h00;
	localparam logic [4:0]  CUB_OFF_THR   = 5'h04;
	localparam logic [4:0]  CUB_OFF_DLY   = 5'h08;
	localparam logic [4:0]  CUB_OFF_RATED = 5'h0c;
	localparam logic [4:0]  CUB_OFF_STAT  = 5'h10;
	localparam logic [4:0]  CUB_OFF_EVT   = 5'h14;
	localparam logic [4:0]  CUB_OFF_MASK  = 5'h18;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int          CUB_CTRL_OP   = 0;
	localparam int          CUB_CTRL_SO   = 1;
	localparam int          CUB_ST_START  = 0;
	localparam int          CUB_ST_TRIP   = 1;
	localparam int          CUB_ST_SPREAD = 2;
	localparam int          CUB_ST_SUFF   = 3;
	localparam int          CUB_ST_NONF   = 4;
	localparam int          CUB_EV_START  = 0;
	localparam int          CUB_EV_TRIP   = 1;
	localparam int          CUB_EV_W      = 2;
	// ----------------------------------------------------------------
	// settings, reset values and ranges
	// ----------------------------------------------------------------
	localparam logic [6:0]  CUB_THR_MIN   = 7'h0a;
	localparam logic [6:0]  CUB_THR_MAX   = 7'h5a;
	localparam logic [6:0]  CUB_THR_RST   = 7'h32;
	localparam logic [15:0] CUB_DLY_MIN   = 16'h0064;
	localparam logic [15:0] CUB_DLY_MAX   = 16'hea60;
	localparam logic [15:0] CUB_DLY_RST   = 16'h03e8;
	localparam logic [6:0]  CUB_PCT_FULL  = 7'h64;
	localparam logic [3:0]  CUB_SUFF_DIV  = 4'ha;
	localparam logic [1:0]  CUB_NF_DEN    = 2'h2;
	localparam logic [1:0]  CUB_NF_NUM    = 2'h3;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          CUB_CLK_NS    = 10;
	localparam int          CUB_MS_NS     = 1000000;
	localparam int          CUB_CYC_PER_MS = CUB_MS_NS / CUB_CLK_NS;
endpackage
`default_nettype wire

// File: cub_eval_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cub_eval_if #(parameter int MAG_W = 16);
	logic             upd;
	logic [MAG_W-1:0] m1;
	logic [MAG_W-1:0] m2;
	logic [MAG_W-1:0] m3;
	logic [MAG_W-1:0] rated;
	logic [6:0]       thr;
	logic             res_vld;
	logic             spread;
	logic             suff;
	logic             nonfault;
	logic [MAG_W-1:0] mx;
	logic [MAG_W-1:0] mn;
	modport ctl  (output upd, m1, m2, m3, rated, thr, input res_vld, spread, suff, nonfault, mx, mn);
	modport eval (input upd, m1, m2, m3, rated, thr, output res_vld, spread, suff, nonfault, mx, mn);
endinterface
`default_nettype wire

// File: cub_eval.sv
`timescale 1ns/100ps
`default_nettype none
module cub_eval #(
	parameter int MAG_W = 16
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	cub_eval_if.eval  e
);
	import cub_pkg::*;

	localparam int PW = MAG_W + 7;

	typedef struct packed {
		logic             vld;
		logic             spread;
		logic             suff;
		logic             nonfault;
		logic [MAG_W-1:0] mx;
		logic [MAG_W-1:0] mn;
	} cub_ev_t;

	cub_ev_t s_r;
	cub_ev_t s_nxt;

	generate
		if (MAG_W < 4 || MAG_W > 24)
		begin : g_chk
			$error("cub_eval: MAG_W out of range");
		end
	endgenerate

	function automatic logic [MAG_W-1:0] pick(input logic [MAG_W-1:0] a, input logic [MAG_W-1:0] b,
		input logic want_max);
		if ((a > b) == want_max)
			pick = a;
		else
			pick = b;
	endfunction

	function automatic logic [PW-1:0] mul(input logic [MAG_W-1:0] a, input logic [6:0] b);
		mul = PW'(a) * PW'(b);
	endfunction

	// ----------------------------------------------------------------
	// magnitude evaluation
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [MAG_W-1:0] mx;
		logic [MAG_W-1:0] mn;
		mx = pick(pick(e.m1, e.m2, 1'b1), e.m3, 1'b1);
		mn = pick(pick(e.m1, e.m2, 1'b0), e.m3, 1'b0);
		s_nxt = s_r;
		s_nxt.vld = e.upd;
		if (e.upd)
		begin
			s_nxt.mx = mx;
			s_nxt.mn = mn;
			s_nxt.spread = mul(mx - mn, CUB_PCT_FULL) > mul(mx, e.thr);
			s_nxt.suff = mul(mx, {3'h0, CUB_SUFF_DIV}) > PW'(e.rated);
			s_nxt.nonfault = mul(mx, {5'h00, CUB_NF_DEN}) < mul(e.rated, {5'h00, CUB_NF_NUM});
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_r <= '0;
		else if (ce)
			s_r <= s_nxt;
	end

	assign e.res_vld  = s_r.vld;
	assign e.spread   = s_r.spread;
	assign e.suff     = s_r.suff;
	assign e.nonfault = s_r.nonfault;
	assign e.mx       = s_r.mx;
	assign e.mn       = s_r.mn;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_max_min_pick: assert property (@(posedge clk) disable iff (!rst_n)
		ce && e.upd |=> s_r.mx >= $past(e.m1) && s_r.mx >= $past(e.m2) && s_r.mx >= $past(e.m3)
			&& s_r.mn <= $past(e.m1) && s_r.mn <= $past(e.m2) && s_r.mn <= $past(e.m3))
		else $error("max or min not selected");
	a_equal_no_spread: assert property (@(posedge clk) disable iff (!rst_n)
		ce && e.upd && e.m1 == e.m2 && e.m2 == e.m3 |=> !s_r.spread)
		else $error("spread flagged for equal phases");
endmodule
`default_nettype wire

// File: cub_top.sv
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cub_top
	import cub_pkg::*;
#(
	parameter int          MAG_W       = 16,
	parameter int          TICK_CYCLES = cub_pkg::CUB_CYC_PER_MS,
	parameter logic [23:0] RATED_DEF   = 24'h001000
) (
	input  wire logic                      CLK,
	input  wire logic                      RSTN,
	input  wire logic                      CE,
	input  wire logic [cub_pkg::CUB_AW-1:0] AVS_ADDRESS,
	input  wire logic                      AVS_READ,
	input  wire logic                      AVS_WRITE,
	input  wire logic [cub_pkg::CUB_DW-1:0] AVS_WRITEDATA,
	output logic      [cub_pkg::CUB_DW-1:0] AVS_READDATA,
	output logic                           AVS_WAITREQUEST,
	input  wire logic                      MAG_UPDATE,
	input  wire logic [MAG_W-1:0]          PHASE1_FUNDAMENTAL_RMS,
	input  wire logic [MAG_W-1:0]          PHASE2_FUNDAMENTAL_RMS,
	input  wire logic [MAG_W-1:0]          PHASE3_FUNDAMENTAL_RMS,
	input  wire logic                      BLOCKING_INPUT,
	output logic                           GENERAL_START_OUT,
	output logic                           GENERAL_TRIP_OUT,
	output logic                           IRQ
);
	import cub_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES + 1);

	typedef struct packed {
		logic              ack;
		logic [CUB_DW-1:0] rdata;
		logic              op;
		logic              start_only;
		logic [6:0]        thr;
		logic [15:0]       dly;
		logic [MAG_W-1:0]  rated;
		logic [CUB_EV_W-1:0] evt;
		logic [CUB_EV_W-1:0] mask;
		logic              spread;
		logic              suff;
		logic              nonfault;
		logic              start;
		logic              trip;
		logic [TW-1:0]     presc;
		logic [15:0]       ms;
	} cub_st_t;

	cub_st_t s_r;
	cub_st_t s_nxt;
	logic    rst_meta_r;
	logic    rst_n;

	generate
		if (TICK_CYCLES < 2 || MAG_W < 4 || MAG_W > 24)
		begin : g_chk
			$error("cub_top: parameter out of range");
		end
	endgenerate

	function automatic logic [6:0] clamp_thr(input logic [31:0] v);
		if (v < 32'(CUB_THR_MIN))
			clamp_thr = CUB_THR_MIN;
		else if (v > 32'(CUB_THR_MAX))
			clamp_thr = CUB_THR_MAX;
		else
			clamp_thr = v[6:0];
	endfunction

	function automatic logic [15:0] clamp_dly(input logic [31:0] v);
		if (v < 32'(CUB_DLY_MIN))
			clamp_dly = CUB_DLY_MIN;
		else if (v > 32'(CUB_DLY_MAX))
			clamp_dly = CUB_DLY_MAX;
		else
			clamp_dly = v[15:0];
	endfunction

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// magnitude evaluation
	// ----------------------------------------------------------------
	cub_eval_if #(.MAG_W(MAG_W)) ev ();

	assign ev.upd   = MAG_UPDATE;
	assign ev.m1    = PHASE1_FUNDAMENTAL_RMS;
	assign ev.m2    = PHASE2_FUNDAMENTAL_RMS;
	assign ev.m3    = PHASE3_FUNDAMENTAL_RMS;
	assign ev.rated = s_r.rated;
	assign ev.thr   = s_r.thr;

	cub_eval #(.MAG_W(MAG_W)) u_eval (
		.clk   (CLK),
		.rst_n (rst_n),
		.ce    (CE),
		.e     (ev.eval)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic                cond;
		logic                acc;
		logic [CUB_EV_W-1:0] set;
		logic [CUB_EV_W-1:0] clr;
		s_nxt = s_r;
		acc   = (AVS_READ || AVS_WRITE) && s_r.ack;
		set   = '0;
		clr   = '0;
		cond  = 1'b0;
		s_nxt.ack = (AVS_READ || AVS_WRITE) && !s_r.ack;
		if (ev.res_vld)
		begin
			s_nxt.spread   = ev.spread;
			s_nxt.suff     = ev.suff;
			s_nxt.nonfault = ev.nonfault;
		end
		cond = s_r.op && !BLOCKING_INPUT && s_r.spread && s_r.suff && s_r.nonfault;
		if (!cond)
		begin
			s_nxt.presc = '0;
			s_nxt.ms    = '0;
		end
		else if (s_r.presc == TW'(TICK_CYCLES - 1))
		begin
			s_nxt.presc = '0;
			if (s_r.ms != 16'hffff)
				s_nxt.ms = s_r.ms + 16'h0001;
		end
		else
			s_nxt.presc = s_r.presc + TW'(1);
		s_nxt.start = cond;
		s_nxt.trip = cond && !s_r.start_only && s_nxt.ms >= s_r.dly;
		set[CUB_EV_START] = s_nxt.start && !s_r.start;
		set[CUB_EV_TRIP]  = s_nxt.trip && !s_r.trip;
		// register read mux
		if (!s_r.ack && AVS_READ)
		begin
			unique case (AVS_ADDRESS)
				CUB_OFF_CTRL:  s_nxt.rdata = CUB_DW'({s_r.start_only, s_r.op});
				CUB_OFF_THR:   s_nxt.rdata = CUB_DW'(s_r.thr);
				CUB_OFF_DLY:   s_nxt.rdata = CUB_DW'(s_r.dly);
				CUB_OFF_RATED: s_nxt.rdata = CUB_DW'(s_r.rated);
				CUB_OFF_STAT:  s_nxt.rdata = CUB_DW'({s_r.nonfault, s_r.suff, s_r.spread, s_r.trip, s_r.start});
				CUB_OFF_EVT:   s_nxt.rdata = CUB_DW'(s_r.evt);
				CUB_OFF_MASK:  s_nxt.rdata = CUB_DW'(s_r.mask);
				default:       s_nxt.rdata = '0;
			endcase
		end
		if (acc && AVS_READ && AVS_ADDRESS == CUB_OFF_EVT)
			clr = s_r.rdata[CUB_EV_W-1:0];
		s_nxt.evt = (s_r.evt & ~clr) | set;
		if (acc && AVS_WRITE)
		begin
			unique case (AVS_ADDRESS)
				CUB_OFF_CTRL:
				begin
					s_nxt.op         = AVS_WRITEDATA[CUB_CTRL_OP];
					s_nxt.start_only = AVS_WRITEDATA[CUB_CTRL_SO];
				end
				CUB_OFF_THR:   s_nxt.thr = clamp_thr(AVS_WRITEDATA);
				CUB_OFF_DLY:   s_nxt.dly = clamp_dly(AVS_WRITEDATA);
				CUB_OFF_RATED: s_nxt.rated = AVS_WRITEDATA[MAG_W-1:0];
				CUB_OFF_MASK:  s_nxt.mask = AVS_WRITEDATA[CUB_EV_W-1:0];
				default:       s_nxt.mask = s_r.mask;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_r       <= '0;
			s_r.thr   <= CUB_THR_RST;
			s_r.dly   <= CUB_DLY_RST;
			s_r.rated <= RATED_DEF[MAG_W-1:0];
		end
		else if (CE)
			s_r <= s_nxt;
	end

	assign AVS_WAITREQUEST   = (AVS_READ || AVS_WRITE) && !s_r.ack;
	assign AVS_READDATA      = s_r.rdata;
	assign GENERAL_START_OUT = s_r.start;
	assign GENERAL_TRIP_OUT  = s_r.trip;
	assign IRQ               = |(s_r.evt & s_r.mask);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_n);

	a_start_cause: assert property ($rose(s_r.start) |-> $past(s_r.spread && s_r.op))
		else $error("start without spread or enable");
	a_start_suff: assert property (CE && !s_r.suff |=> !s_r.start)
		else $error("start with low current");
	a_start_nonfault: assert property (CE && !s_r.nonfault |=> !s_r.start)
		else $error("start with fault current");
	a_off_quiet: assert property (CE && !s_r.op |=> !s_r.start && !s_r.trip)
		else $error("output while disabled");
	a_block_quiet: assert property (CE && BLOCKING_INPUT |=> !s_r.start && !s_r.trip)
		else $error("output while blocked");
	a_trip_delay: assert property ($rose(s_r.trip) |-> s_r.start && s_r.ms >= s_r.dly)
		else $error("trip before delay");
	a_thr_range: assert property (s_r.thr >= CUB_THR_MIN && s_r.thr <= CUB_THR_MAX)
		else $error("threshold out of range");
	a_dly_range: assert property (s_r.dly >= CUB_DLY_MIN && s_r.dly <= CUB_DLY_MAX)
		else $error("delay out of range");
	a_timer_origin: assert property ($rose(s_r.start) |-> s_r.ms == 16'h0000)
		else $error("timer not started with condition");
	a_start_only: assert property (CE && s_r.start_only |=> !s_r.trip)
		else $error("trip in start-only mode");
	a_drop_clears: assert property ($fell(s_r.start) |-> !s_r.trip && s_r.ms == 16'h0000)
		else $error("timer or trip kept after drop");

	// ----------------------------------------------------------------
	// flag, start and trip output, timer, event and register write checks
	// ----------------------------------------------------------------
	a_spread_latch: assert property (CE && ev.res_vld |=> s_r.spread == $past(ev.spread))
		else $error("spread flag not taken");
	a_suff_latch: assert property (CE && ev.res_vld |=> s_r.suff == $past(ev.suff))
		else $error("sufficient flag not taken");
	a_nonfault_latch: assert property (CE && ev.res_vld |=> s_r.nonfault == $past(ev.nonfault))
		else $error("nonfault flag not taken");
	a_start_full: assert property (CE && s_r.op && !BLOCKING_INPUT && s_r.spread && s_r.suff && s_r.nonfault
		|=> s_r.start)
		else $error("start missing with condition present");
	a_trip_needs_start: assert property (s_r.trip |-> s_r.start)
		else $error("trip without start");
	a_trip_due: assert property (CE && s_r.op && !BLOCKING_INPUT && s_r.spread && s_r.suff && s_r.nonfault
		&& !s_r.start_only && s_r.ms >= s_r.dly |=> s_r.trip)
		else $error("trip missing after delay");
	a_timer_idle: assert property (!s_r.start |-> s_r.ms == 16'h0000)
		else $error("timer running without start");
	a_block_timer: assert property (CE && BLOCKING_INPUT |=> s_r.ms == 16'h0000)
		else $error("timer running while blocked");
	a_off_timer: assert property (CE && !s_r.op |=> s_r.ms == 16'h0000)
		else $error("timer running while disabled");
	a_start_event: assert property ($rose(s_r.start) |-> s_r.evt[CUB_EV_START])
		else $error("start rise not recorded");
	a_trip_event: assert property ($rose(s_r.trip) |-> s_r.evt[CUB_EV_TRIP])
		else $error("trip rise not recorded");
	a_thr_write: assert property (CE && AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == CUB_OFF_THR
		&& AVS_WRITEDATA >= 32'(CUB_THR_MIN) && AVS_WRITEDATA <= 32'(CUB_THR_MAX)
		|=> s_r.thr == $past(AVS_WRITEDATA[6:0]))
		else $error("threshold write lost");
	a_dly_write: assert property (CE && AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == CUB_OFF_DLY
		&& AVS_WRITEDATA >= 32'(CUB_DLY_MIN) && AVS_WRITEDATA <= 32'(CUB_DLY_MAX)
		|=> s_r.dly == $past(AVS_WRITEDATA[15:0]))
		else $error("delay write lost");

	// ----------------------------------------------------------------
	// scenario covers
	// ----------------------------------------------------------------

	c_start: cover property ($rose(s_r.start));
	c_trip: cover property ($rose(s_r.trip));
	c_irq: cover property ($rose(IRQ));
	c_evt_read: cover property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == CUB_OFF_EVT);
	c_trip_drop: cover property ($fell(s_r.trip));
endmodule
`default_nettype wire

// File: cub_partner.sv
`timescale 1ns/100ps
`default_nettype none
module cub_partner (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  gap,
	input  wire logic [15:0] r1,
	input  wire logic [15:0] r2,
	input  wire logic [15:0] r3,
	input  wire logic        blk_req,
	output logic             upd,
	output logic      [15:0] p1,
	output logic      [15:0] p2,
	output logic      [15:0] p3,
	output logic             blk
);
	// ----------------------------------------------------------------
	// upstream magnitudes, lines toggle between updates
	// ----------------------------------------------------------------
	logic [3:0] cnt_r;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_r <= 4'h0;
			upd   <= 1'b0;
			p1    <= 16'h0000;
			p2    <= 16'h0000;
			p3    <= 16'h0000;
		end
		else if (cnt_r == 4'h0)
		begin
			cnt_r <= gap;
			upd   <= 1'b1;
			p1    <= r1;
			p2    <= r2;
			p3    <= r3;
		end
		else
		begin
			cnt_r <= cnt_r - 4'h1;
			upd   <= 1'b0;
			p1    <= ~p1;
			p2    <= ~p2;
			p3    <= ~p3;
		end
	end
	// ----------------------------------------------------------------
	// downstream blocking logic
	// ----------------------------------------------------------------
	// registered blocking output
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			blk <= 1'b0;
		else
			blk <= blk_req;
	end
endmodule
`default_nettype wire

// File: cub_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cub_top_tb;
	import cub_pkg::*;
	logic        clk;
	logic        rst_n;
	logic        ce;
	logic [4:0]  addr;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        wreq;
	logic        upd;
	logic [15:0] p1;
	logic [15:0] p2;
	logic [15:0] p3;
	logic        blk;
	logic        start;
	logic        trip;
	logic        irq;
	logic [3:0]  gap;
	logic [15:0] r1;
	logic [15:0] r2;
	logic [15:0] r3;
	logic        blk_req;
	int          fails;
	int          cmp_count;
	int          cyc;
	int          n;
	cub_top #(.TICK_CYCLES(4)) u_dut (.CLK(clk), .RSTN(rst_n), .CE(ce), .AVS_ADDRESS(addr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
		.MAG_UPDATE(upd), .PHASE1_FUNDAMENTAL_RMS(p1), .PHASE2_FUNDAMENTAL_RMS(p2),
		.PHASE3_FUNDAMENTAL_RMS(p3), .BLOCKING_INPUT(blk), .GENERAL_START_OUT(start),
		.GENERAL_TRIP_OUT(trip), .IRQ(irq));
	cub_partner u_far (.clk(clk), .rst_n(rst_n), .gap(gap), .r1(r1), .r2(r2), .r3(r3),
		.blk_req(blk_req), .upd(upd), .p1(p1), .p2(p2), .p3(p3), .blk(blk));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		do
			@(posedge clk);
		while (wreq !== 1'b0 && ++k < 40);
		chk(32'(k < 40), 32'h1);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wrt(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic mag(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c, input logic e);
		r1 <= a;
		r2 <= b;
		r3 <= c;
		repeat (30) @(posedge clk);
		chk(32'(start), 32'(e));
	endtask
	// ----------------------------------------------------------------
	// clock and timeout
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			fails++;
			stop_test();
		end
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		ce = 1'b1;
		addr = 5'h00;
		rd = 1'b0;
		wr = 1'b0;
		wdata = 32'h0;
		gap = 4'h0;
		r1 = 16'h01f4;
		r2 = 16'h03e8;
		r3 = 16'h07d0;
		blk_req = 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rdc(CUB_OFF_CTRL, 32'h0);
		rdc(CUB_OFF_THR, 32'h32);
		rdc(CUB_OFF_DLY, 32'h3e8);
		rdc(CUB_OFF_RATED, 32'h1000);
		rdc(CUB_OFF_MASK, 32'h0);
		rdc(CUB_OFF_EVT, 32'h0);
		wrt(5'h1c, 32'hffff);
		rdc(5'h1c, 32'h0);
		wrt(CUB_OFF_THR, 32'h05);
		rdc(CUB_OFF_THR, 32'h0a);
		wrt(CUB_OFF_THR, 32'h5f);
		rdc(CUB_OFF_THR, 32'h5a);
		wrt(CUB_OFF_DLY, 32'h32);
		rdc(CUB_OFF_DLY, 32'h64);
		wrt(CUB_OFF_DLY, 32'hffff);
		rdc(CUB_OFF_DLY, 32'hea60);
		wrt(CUB_OFF_THR, 32'h32);
		wrt(CUB_OFF_DLY, 32'h64);
		repeat (10) @(posedge clk);
		chk(32'(start | trip), 32'h0);
		wrt(CUB_OFF_CTRL, 32'h1);
		wrt(CUB_OFF_MASK, 32'h3);
		repeat (6) @(posedge clk);
		chk(32'(start), 32'h1);
		rdc(CUB_OFF_STAT, 32'h1d);
		repeat (250) @(posedge clk);
		chk(32'(trip), 32'h0);
		r3 <= 16'h01f4;
		r2 <= 16'h01f4;
		repeat (10) @(posedge clk);
		chk(32'(start | trip), 32'h0);
		r3 <= 16'h07d0;
		n = 0;
		while (trip !== 1'b1 && n < 1000)
		begin
			@(posedge clk);
			n++;
		end
		chk(32'(n >= 395 && n <= 410), 32'h1);
		chk(32'(irq), 32'h1);
		rdc(CUB_OFF_EVT, 32'h3);
		chk(32'(irq), 32'h0);
		wrt(CUB_OFF_MASK, 32'h0);
		blk_req <= 1'b1;
		repeat (4) @(posedge clk);
		chk(32'(start | trip), 32'h0);
		blk_req <= 1'b0;
		repeat (10) @(posedge clk);
		chk(32'(irq), 32'h0);
		rdc(CUB_OFF_EVT, 32'h1);
		wrt(CUB_OFF_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		chk(32'(start | trip), 32'h0);
		wrt(CUB_OFF_CTRL, 32'h3);
		repeat (500) @(posedge clk);
		chk(32'({start, trip}), 32'h2);
		gap <= 4'h7;
		mag(16'd2000, 16'd1000, 16'd1000, 1'b0);
		mag(16'd999, 16'd2000, 16'd1000, 1'b1);
		mag(16'd409, 16'd0, 16'd0, 1'b0);
		mag(16'd0, 16'd410, 16'd0, 1'b1);
		mag(16'd6144, 16'd0, 16'd3000, 1'b0);
		mag(16'd6143, 16'd3000, 16'd0, 1'b1);
		ce <= 1'b0;
		mag(16'd500, 16'd500, 16'd500, 1'b1);
		ce <= 1'b1;
		mag(16'd500, 16'd500, 16'd500, 1'b0);
		wrt(CUB_OFF_RATED, 32'hffff0800);
		rdc(CUB_OFF_RATED, 32'h800);
		mag(16'd204, 16'd0, 16'd0, 1'b0);
		mag(16'd205, 16'd0, 16'd0, 1'b1);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		chk(32'(start | trip), 32'h0);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rdc(CUB_OFF_RATED, 32'h1000);
		rdc(CUB_OFF_CTRL, 32'h0);
		rdc(CUB_OFF_THR, 32'h32);
		stop_test();
	end
endmodule
`default_nettype wire
